//--- verilog/abr_pkg.sv
package abr_pkg;

	// Register addresses on the management bus
	localparam logic [4:0]  ADR_IDENT2  = 5'h03;
	localparam logic [4:0]  ADR_ADVERT  = 5'h04;
	localparam logic [4:0]  ADR_PARTNER = 5'h05;
	localparam logic [4:0]  ADR_EXPAN   = 5'h06;
	localparam logic [4:0]  ADR_SETUP   = 5'h10;

	// Reset values, writable masks and the partner capture mask
	localparam logic [15:0] ADV_RST     = 16'h01e1;
	localparam logic [15:0] ADV_WMASK   = 16'h25ff;
	localparam logic [15:0] PAR_RST     = 16'h0080;
	localparam logic [15:0] PAR_MASK    = 16'he7ff;
	localparam logic [15:0] EXP_RST     = 16'h0000;
	localparam logic [15:0] SET_RST     = 16'h0000;
	localparam logic [15:0] SET_WMASK   = 16'h0e00;

	// Field positions
	localparam int          ADV_NP      = 15;
	localparam int          ADV_ACK     = 14;
	localparam int          ADV_T4      = 9;
	localparam int          PAR_FAST    = 7;
	localparam int          PAR_TEN     = 5;
	localparam int          EXP_MLF     = 4;
	localparam int          EXP_PNP     = 3;
	localparam int          EXP_LNP     = 2;
	localparam int          EXP_PAGE    = 1;
	localparam int          EXP_PAN     = 0;
	localparam int          SET_LED     = 11;
	localparam int          SET_FAST    = 10;
	localparam int          SET_LOOP    = 9;
	localparam int          SET_ABD     = 2;
	localparam int          SET_PDF     = 1;
	localparam int          SET_LSC     = 0;

	// Management frame layout
	localparam logic [1:0]  OP_RD       = 2'h2;
	localparam logic [1:0]  OP_WR       = 2'h1;
	localparam logic [5:0]  PRE_BITS    = 6'h20;
	localparam logic [5:0]  ONES_MAX    = 6'h3f;
	localparam logic [4:0]  HDR_LAST    = 5'h0b;
	localparam logic [4:0]  TA_LAST     = 5'h01;
	localparam logic [4:0]  DATA_LAST   = 5'h0f;
	localparam logic [4:0]  SKIP_LAST   = 5'h11;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_HDR   = 3'b011,
		ST_TA    = 3'b010,
		ST_DATA  = 3'b110,
		ST_SKIP  = 3'b100
	} abr_state_t;

	function automatic logic [15:0] abr_merge(input logic [15:0] old,
		input logic [15:0] wd, input logic [15:0] mask);
		abr_merge = (old & ~mask) | (wd & mask);
	endfunction

endpackage

//--- verilog/abr_sync.sv
`timescale 1ns/10ps
module abr_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_d,
	output logic      [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] meta_q;

	if (WIDTH < 1) begin : g_bad_width
		$error("abr_sync needs WIDTH of at least one");
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= '0;
			o_q    <= '0;
		end else begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end
endmodule

//--- verilog/abr_rst_sync.sv
`timescale 1ns/10ps
module abr_rst_sync (
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	output logic      o_rst_n
);
	logic meta_q;

	// Assert at once, release only after two clean edges
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_q  <= 1'b0;
			o_rst_n <= 1'b0;
		end else begin
			meta_q  <= 1'b1;
			o_rst_n <= meta_q;
		end
	end
endmodule

//--- verilog/abr_ability_regs.sv
// How it works
// - Advertisement register contents are driven out as the local ability word.
// - Advertisement next-page and acknowledge bits are read-only zero.
// - Advertisement bit 13 is writable, resets zero, advertises remote fault.
// - Advertisement bit 10 is writable, resets zero, advertises flow control.
// - Advertisement bit 9 for T4 is read-only and reads zero.
// - Advertisement bits 8..5 are writable speed and duplex abilities, reset one.
// - Advertisement bits 4..0 are a writable selector resetting to CSMA/CD.
// - Partner register captures each received partner ability word.
// - Partner bit 14 reports partner acknowledge, read-only, resets zero.
// - Partner bit 13 reports partner remote fault, read-only, resets zero.
// - Partner bits 10, 9, 8, 6 are read-only ability bits, reset zero.
// - Partner bit 7 resets one and is set by 100 Mb/s parallel detect.
// - Partner bit 5 resets zero and is set by 10 Mb/s parallel detect.
// - Partner bits 4..0 hold the received selector, read-only, reset zero.
// - Expansion bits 15..5 always read zero.
// - Expansion bit 4 is a sticky multiple link fault flag.
// - Expansion bits 3 and 2 report partner and local next-page ability.
// - Expansion bit 1 sets on a new page, clears on partner register read.
// - Expansion bit 0 reports that the partner can negotiate.
// - Setup bit 11 switches the fourth LED to show link pulses.
// - Setup bits 10 and 9 select fast timers and negotiation loopback.
// - Setup bits 2..0 are sticky read-only state history flags.
// - All registers are reached over the serial management clock and data pins.
`timescale 1ns/10ps
module abr_ability_regs
	import abr_pkg::*;
#(
	parameter logic [4:0]  PHY_ADDR  = 5'h01,
	parameter logic [5:0]  PRE_MIN   = abr_pkg::PRE_BITS,
	// Identification value is arbitrary
	parameter logic [15:0] IDENT_TWO = 16'h5a3c
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_mdc,
	input  wire logic        i_mdio_in,
	output logic             o_mdio_out,
	output logic             o_mdio_oe,
	input  wire logic        i_page_valid,
	input  wire logic [15:0] i_page_word,
	input  wire logic        i_pardet_fast,
	input  wire logic        i_pardet_ten,
	input  wire logic        i_multi_link_fault_event,
	input  wire logic        i_partner_next_page_capable,
	input  wire logic        i_local_next_page_capable,
	input  wire logic        i_partner_negotiation_capable,
	input  wire logic        i_ability_detect_event,
	input  wire logic        i_parallel_fault_event,
	input  wire logic        i_link_check_event,
	input  wire logic        i_link_pulse,
	input  wire logic        i_fourth_led_output_normal,
	output logic [15:0]      o_advert_word,
	output logic             o_timer_speedup,
	output logic             o_negotiation_loop_en,
	output logic             o_fourth_led_output
);
	import abr_pkg::*;

	logic        rst_n;
	logic [1:0]  pin_s;
	logic        mdc_s;
	logic        mdio_s;
	logic        mdc_prev_q;
	logic        rise;
	abr_state_t  st_q,     st_d;
	logic [4:0]  cnt_q,    cnt_d;
	logic [5:0]  ones_q,   ones_d;
	logic        pre_ok_q, pre_ok_d;
	logic [11:0] hdr_q,    hdr_d;
	logic [15:0] sh_q,     sh_d;
	logic        rd_op_q,  rd_op_d;
	logic        oe_q,     oe_d;
	logic        out_q,    out_d;
	logic        wr_stb;
	logic        rd_stb;
	logic [15:0] adv_q,    adv_d;
	logic [15:0] par_q,    par_d;
	logic [15:0] exp_q,    exp_d;
	logic [15:0] set_q,    set_d;
	logic        led_q,    led_d;
	logic        wr_fast;

	if (PRE_MIN == 6'h00 || PRE_MIN == ONES_MAX) begin : g_bad_pre
		$error("abr_ability_regs: PRE_MIN out of range");
	end

	abr_rst_sync u_rst (
		.i_clk    (i_ref_clk),
		.i_arst_n (i_arst_n),
		.o_rst_n  (rst_n)
	);

	// Both pins come from the management master's domain
	abr_sync #(.WIDTH(2)) u_pin_sync (
		.i_clk   (i_ref_clk),
		.i_rst_n (rst_n),
		.i_d     ({i_mdc, i_mdio_in}),
		.o_q     (pin_s)
	);

	assign mdc_s  = pin_s[1];
	assign mdio_s = pin_s[0];
	// The sync delay means the clock must run at least four times the
	// management clock, or the read data would miss its set-up window.
	assign rise   = mdc_s & ~mdc_prev_q;

	function automatic logic [15:0] rd_mux(input logic [4:0] a);
		case (a)
			ADR_IDENT2:  rd_mux = IDENT_TWO;
			ADR_ADVERT:  rd_mux = adv_q;
			ADR_PARTNER: rd_mux = par_q;
			ADR_EXPAN:   rd_mux = exp_q;
			ADR_SETUP:   rd_mux = set_q;
			default:     rd_mux = 16'h0000;
		endcase
	endfunction

	// Serial frame engine, one step per management clock rising edge
	always_comb begin
		st_d     = st_q;
		cnt_d    = cnt_q;
		ones_d   = ones_q;
		pre_ok_d = pre_ok_q;
		hdr_d    = hdr_q;
		sh_d     = sh_q;
		rd_op_d  = rd_op_q;
		oe_d     = oe_q;
		out_d    = out_q;
		wr_stb   = 1'b0;
		rd_stb   = 1'b0;
		if (rise) begin
			case (st_q)
				ST_IDLE: begin
					if (mdio_s) begin
						if (ones_q != ONES_MAX) begin
							ones_d = ones_q + 6'h01;
						end
					end else if (pre_ok_q || ones_q >= PRE_MIN) begin
						st_d = ST_START;
					end else begin
						ones_d = 6'h00;
					end
				end
				ST_START: begin
					cnt_d  = 5'h00;
					ones_d = 6'h00;
					if (mdio_s) begin
						st_d     = ST_HDR;
						// Full preamble seen once; later frames may skip it
						pre_ok_d = 1'b1;
					end else begin
						st_d = ST_IDLE;
					end
				end
				ST_HDR: begin
					hdr_d = {hdr_q[10:0], mdio_s};
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == HDR_LAST) begin
						cnt_d = 5'h00;
						if (hdr_d[9:5] == PHY_ADDR &&
							(hdr_d[11:10] == OP_RD || hdr_d[11:10] == OP_WR)) begin
							st_d    = ST_TA;
							rd_op_d = (hdr_d[11:10] == OP_RD);
							rd_stb  = (hdr_d[11:10] == OP_RD);
							sh_d    = rd_mux(hdr_d[4:0]);
						end else begin
							// Ride out the frame so its data cannot fake a start
							st_d = ST_SKIP;
						end
					end
				end
				ST_TA: begin
					cnt_d = cnt_q + 5'h01;
					if (cnt_q != TA_LAST) begin
						if (rd_op_q) begin
							oe_d  = 1'b1;
							out_d = 1'b0;
						end
					end else begin
						cnt_d = 5'h00;
						st_d  = ST_DATA;
						if (rd_op_q) begin
							out_d = sh_q[15];
							sh_d  = {sh_q[14:0], 1'b0};
						end
					end
				end
				ST_DATA: begin
					cnt_d = cnt_q + 5'h01;
					if (rd_op_q) begin
						out_d = sh_q[15];
						sh_d  = {sh_q[14:0], 1'b0};
					end else begin
						sh_d = {sh_q[14:0], mdio_s};
					end
					if (cnt_q == DATA_LAST) begin
						st_d   = ST_IDLE;
						cnt_d  = 5'h00;
						oe_d   = 1'b0;
						out_d  = 1'b0;
						wr_stb = ~rd_op_q;
					end
				end
				ST_SKIP: begin
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == SKIP_LAST) begin
						st_d  = ST_IDLE;
						cnt_d = 5'h00;
					end
				end
				default: begin
					st_d  = ST_IDLE;
					cnt_d = 5'h00;
					oe_d  = 1'b0;
					out_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mdc_prev_q <= 1'b0;
			st_q       <= ST_IDLE;
			cnt_q      <= 5'h00;
			ones_q     <= 6'h00;
			pre_ok_q   <= 1'b0;
			hdr_q      <= 12'h000;
			sh_q       <= 16'h0000;
			rd_op_q    <= 1'b0;
			oe_q       <= 1'b0;
			out_q      <= 1'b0;
		end else begin
			mdc_prev_q <= mdc_s;
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			ones_q     <= ones_d;
			pre_ok_q   <= pre_ok_d;
			hdr_q      <= hdr_d;
			sh_q       <= sh_d;
			rd_op_q    <= rd_op_d;
			oe_q       <= oe_d;
			out_q      <= out_d;
		end
	end

	// Register bank
	always_comb begin
		adv_d = adv_q;
		par_d = par_q;
		exp_d = exp_q;
		set_d = set_q;
		if (wr_stb) begin
			case (hdr_q[4:0])
				// Masks hold read-only and reserved bits at their value
				ADR_ADVERT: adv_d = abr_merge(adv_q, sh_d, ADV_WMASK);
				ADR_SETUP:  set_d = abr_merge(set_q, sh_d, SET_WMASK);
				default:    adv_d = adv_q;
			endcase
		end
		if (i_page_valid) begin
			par_d = i_page_word & PAR_MASK;
		end
		if (i_pardet_fast) begin
			par_d[PAR_FAST] = 1'b1;
		end
		if (i_pardet_ten) begin
			par_d[PAR_TEN] = 1'b1;
		end
		// Clear on read first so a same-cycle page still leaves it set
		if (rd_stb && hdr_d[4:0] == ADR_PARTNER) begin
			exp_d[EXP_PAGE] = 1'b0;
		end
		if (i_page_valid) begin
			exp_d[EXP_PAGE] = 1'b1;
		end
		if (i_multi_link_fault_event) begin
			exp_d[EXP_MLF] = 1'b1;
		end
		exp_d[EXP_PNP] = i_partner_next_page_capable;
		exp_d[EXP_LNP] = i_local_next_page_capable;
		exp_d[EXP_PAN] = i_partner_negotiation_capable;
		if (i_ability_detect_event) begin
			set_d[SET_ABD] = 1'b1;
		end
		if (i_parallel_fault_event) begin
			set_d[SET_PDF] = 1'b1;
		end
		if (i_link_check_event) begin
			set_d[SET_LSC] = 1'b1;
		end
		led_d = set_q[SET_LED] ? i_link_pulse : i_fourth_led_output_normal;
	end

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			adv_q <= ADV_RST;
			par_q <= PAR_RST;
			exp_q <= EXP_RST;
			set_q <= SET_RST;
			led_q <= 1'b0;
		end else begin
			adv_q <= adv_d;
			par_q <= par_d;
			exp_q <= exp_d;
			set_q <= set_d;
			led_q <= led_d;
		end
	end

	assign o_advert_word         = adv_q;
	assign o_timer_speedup       = set_q[SET_FAST];
	assign o_negotiation_loop_en = set_q[SET_LOOP];
	assign o_fourth_led_output   = led_q;
	assign o_mdio_out            = out_q;
	assign o_mdio_oe             = oe_q;
	assign wr_fast               = sh_d[SET_FAST];

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!rst_n);

	chk_adv_fixed_zero: assert property (
		!adv_q[ADV_NP] && !adv_q[ADV_ACK] && !adv_q[ADV_T4])
		else $error("advert read-only bit became set");

	chk_adv_write: assert property (
		wr_stb && hdr_q[4:0] == ADR_ADVERT
		|=> o_advert_word == ($past(sh_d) & ADV_WMASK))
		else $error("advert word does not follow the write");

	chk_par_capture: assert property (
		i_page_valid && !i_pardet_fast && !i_pardet_ten
		|=> par_q == ($past(i_page_word) & PAR_MASK))
		else $error("partner word not captured");

	chk_par_fast: assert property (
		i_pardet_fast |=> par_q[PAR_FAST])
		else $error("fast parallel detect not shown");

	chk_par_ten: assert property (
		i_pardet_ten |=> par_q[PAR_TEN])
		else $error("ten parallel detect not shown");

	chk_page_set_wins: assert property (
		i_page_valid |=> exp_q[EXP_PAGE])
		else $error("page flag lost");

	chk_page_rd_clear: assert property (
		rd_stb && hdr_d[4:0] == ADR_PARTNER && !i_page_valid
		|=> !exp_q[EXP_PAGE])
		else $error("page flag not cleared by partner read");

	chk_exp_reserved: assert property (
		exp_q[15:5] == 11'h000 && o_advert_word[12:11] == 2'h0)
		else $error("reserved bits not zero");

	chk_mlf_sticky: assert property (
		i_multi_link_fault_event |=> exp_q[EXP_MLF] [*3])
		else $error("multiple link fault flag not sticky");

	chk_flag_history: assert property (
		i_ability_detect_event |=> set_q[SET_ABD] ##1 set_q[SET_ABD])
		else $error("ability detect flag not sticky");

	chk_led_select: assert property (
		set_q[SET_LED] |=> o_fourth_led_output == $past(i_link_pulse))
		else $error("fourth LED not showing link pulses");

	chk_setup_write: assert property (
		wr_stb && hdr_q[4:0] == ADR_SETUP |=> o_timer_speedup == $past(wr_fast))
		else $error("timer speed-up does not follow the write");

	chk_setup_ro: assert property (
		wr_stb && hdr_q[4:0] == ADR_SETUP && !i_ability_detect_event &&
		!i_parallel_fault_event && !i_link_check_event
		|=> $stable(set_q[SET_ABD:SET_LSC]))
		else $error("write changed read-only setup flags");

	chk_read_release: assert property (
		rise && st_q == ST_DATA && cnt_q == DATA_LAST
		|=> !o_mdio_oe ##1 st_q == ST_IDLE)
		else $error("data pin not released after read");

endmodule

//--- bench/abr_mgmt_model.sv
`timescale 1ns/10ps
module abr_mgmt_model
	import abr_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_mdio_out,
	input  wire logic i_mdio_oe,
	output logic      o_mdc,
	output logic      o_mdio
);
	logic drive_q;
	logic bit_q;
	logic seen_oe;

	// Pull-up holds the shared line high when nobody drives it
	assign o_mdio = i_mdio_oe ? i_mdio_out : (drive_q ? bit_q : 1'b1);

	initial begin
		o_mdc   = 1'b0;
		drive_q = 1'b0;
		bit_q   = 1'b1;
		seen_oe = 1'b0;
	end

	// 16 reference cycles a bit keeps the clock well under a quarter rate
	task automatic one_bit(input logic drv, input logic v, output logic smp);
		@(posedge i_clk);
		o_mdc   <= 1'b0;
		drive_q <= drv;
		bit_q   <= v;
		repeat (8) @(posedge i_clk) seen_oe |= i_mdio_oe;
		o_mdc <= 1'b1;
		@(posedge i_clk);
		smp = o_mdio;
		repeat (6) @(posedge i_clk) seen_oe |= i_mdio_oe;
	endtask

	task automatic frame(input int pre, input logic [1:0] op,
		input logic [4:0] phy, input logic [4:0] adr,
		input logic [15:0] wd, output logic [15:0] rd);
		logic        s;
		logic [13:0] hdr;
		hdr     = {2'b01, op, phy, adr};
		seen_oe = 1'b0;
		rd      = 16'h0000;
		repeat (pre) one_bit(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--) begin
			one_bit(1'b1, hdr[i], s);
		end
		// A read releases the line from the turnaround on
		for (int i = 17; i >= 0; i--) begin
			one_bit(op != OP_RD, (i > 15) ? (i == 17) : wd[i], s);
			if (i < 16) begin
				rd[i] = s;
			end
		end
		one_bit(1'b1, 1'b1, s);
		@(posedge i_clk);
		o_mdc   <= 1'b0;
		drive_q <= 1'b0;
	endtask
endmodule

//--- bench/autoneg_ability_registers_bench.sv
`timescale 1ns/10ps
module autoneg_ability_registers_bench;
	import abr_pkg::*;

	// Arbitrary identification value
	localparam logic [15:0] ID2 = 16'h6c21;
	logic        i_ref_clk;
	logic        i_arst_n;
	logic        mdc;
	logic        mdio;
	logic        mdio_out;
	logic        mdio_oe;
	logic [6:0]  ev;
	logic [4:0]  lv;
	logic [15:0] pw;
	logic [15:0] advert;
	logic        speedup;
	logic        loop_en;
	logic        fourth_led_output;
	logic [31:0] seed;
	logic [15:0] e_adv;
	logic [15:0] e_par;
	logic [15:0] e_set;
	logic [15:0] rd;
	logic [15:0] w;
	int          bad_count;
	int          n_checks;

	abr_ability_regs #(.IDENT_TWO(ID2)) u_dut (
		.i_ref_clk                    (i_ref_clk),
		.i_arst_n                     (i_arst_n),
		.i_mdc                        (mdc),
		.i_mdio_in                    (mdio),
		.o_mdio_out                   (mdio_out),
		.o_mdio_oe                    (mdio_oe),
		.i_page_valid                 (ev[0]),
		.i_page_word                  (pw),
		.i_pardet_fast                (ev[1]),
		.i_pardet_ten                 (ev[2]),
		.i_multi_link_fault_event     (ev[3]),
		.i_partner_next_page_capable  (lv[0]),
		.i_local_next_page_capable    (lv[1]),
		.i_partner_negotiation_capable(lv[2]),
		.i_ability_detect_event       (ev[4]),
		.i_parallel_fault_event       (ev[5]),
		.i_link_check_event           (ev[6]),
		.i_link_pulse                 (lv[3]),
		.i_fourth_led_output_normal                (lv[4]),
		.o_advert_word                (advert),
		.o_timer_speedup              (speedup),
		.o_negotiation_loop_en        (loop_en),
		.o_fourth_led_output          (fourth_led_output)
	);

	abr_mgmt_model u_mgmt (
		.i_clk     (i_ref_clk),
		.i_mdio_out(mdio_out),
		.i_mdio_oe (mdio_oe),
		.o_mdc     (mdc),
		.o_mdio    (mdio)
	);

	always #25 i_ref_clk = ~i_ref_clk;

	function automatic logic [15:0] rnd16();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction

	function automatic logic [15:0] upd(input logic [15:0] o,
		input logic [15:0] v, input logic [15:0] m);
		return (o & ~m) | (v & m);
	endfunction

	function automatic logic [15:0] exp_val(input logic f, input logic pg);
		return {11'h000, f, lv[0], lv[1], pg, lv[2]};
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
		u_mgmt.frame(0, OP_RD, 5'h01, a, 16'h0000, rd);
		chk(rd, exp);
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		u_mgmt.frame(0, OP_WR, 5'h01, a, d, rd);
	endtask

	task automatic fire(input logic [6:0] m, input logic [15:0] d);
		@(posedge i_ref_clk);
		ev <= m;
		pw <= d;
		@(posedge i_ref_clk);
		ev <= 7'h00;
		repeat (2) @(posedge i_ref_clk);
	endtask

	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		// About sixty frames of some five hundred cycles each, with margin
		repeat (60000) @(posedge i_ref_clk);
		bad_count++;
		stop_test();
	end

	initial begin
		i_ref_clk = 1'b0;
		i_arst_n  = 1'b0;
		ev        = 7'h00;
		lv        = 5'h00;
		pw        = 16'h0000;
		seed      = 32'h3af1f407;
		bad_count = 0;
		n_checks  = 0;
		repeat (2) @(posedge i_ref_clk);
		i_arst_n <= 1'b1;
		#1;
		chk(advert, 16'h01e1);
		chk({13'h0, speedup, loop_en, fourth_led_output}, 16'h0000);
		repeat (4) @(posedge i_ref_clk);
		u_mgmt.frame(32, OP_RD, 5'h01, ADR_IDENT2, 16'h0000, rd);
		chk(rd, ID2);
		rdchk(ADR_ADVERT, 16'h01e1);
		rdchk(ADR_PARTNER, 16'h0080);
		rdchk(ADR_EXPAN, 16'h0000);
		rdchk(ADR_SETUP, 16'h0000);
		rdchk(5'h07, 16'h0000);
		e_adv = 16'h01e1;
		e_set = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : rnd16();
			wr(ADR_ADVERT, w);
			e_adv = upd(e_adv, w, 16'h25ff);
			wr(ADR_SETUP, ~w);
			e_set = upd(e_set, ~w, 16'h0e00);
			wr(ADR_PARTNER, w);
			wr(ADR_EXPAN, w);
			wr(ADR_IDENT2, w);
			wr(5'h11, w);
			chk(advert, e_adv);
			chk({14'h0, speedup, loop_en}, {14'h0, e_set[10:9]});
			rdchk(ADR_ADVERT, e_adv);
			rdchk(ADR_SETUP, e_set);
		end
		rdchk(ADR_PARTNER, 16'h0080);
		rdchk(ADR_IDENT2, ID2);
		// Bit 11 picks which source reaches the fourth indicator
		for (int s = 1; s >= 0; s--) begin
			wr(ADR_SETUP, s[0] ? 16'h0800 : 16'h0000);
			for (int i = 0; i < 4; i++) begin
				@(posedge i_ref_clk);
				lv[4:3] <= i[1:0];
				repeat (2) @(posedge i_ref_clk);
				#1;
				chk({15'h0, fourth_led_output}, {15'h0, s[0] ? i[0] : i[1]});
			end
		end
		e_set = 16'h0000;
		for (int i = 0; i < 3; i++) begin
			@(posedge i_ref_clk);
			lv[2:0] <= 3'(rnd16());
			w = (i == 0) ? 16'hffff : rnd16() & 16'hff5f;
			fire(7'h01, w);
			e_par = w & 16'he7ff;
			if (i == 1) begin
				fire(7'h06, 16'h0000);
				e_par = e_par | 16'h00a0;
			end
			fire(7'h10 << i, 16'h0000);
			e_set = e_set | (16'h0004 >> i);
			if (i == 2) begin
				fire(7'h08, 16'h0000);
			end
			rdchk(ADR_EXPAN, exp_val(i == 2, 1'b1));
			rdchk(ADR_PARTNER, e_par);
			rdchk(ADR_EXPAN, exp_val(i == 2, 1'b0));
			rdchk(ADR_SETUP, e_set);
		end
		u_mgmt.frame(0, OP_RD, 5'h02, ADR_ADVERT, 16'h0000, rd);
		chk({15'h0, u_mgmt.seen_oe}, 16'h0000);
		u_mgmt.frame(0, 2'h0, 5'h01, ADR_ADVERT, 16'h0000, rd);
		u_mgmt.frame(0, OP_WR, 5'h03, ADR_ADVERT, 16'h0000, rd);
		rdchk(ADR_ADVERT, e_adv);
		i_arst_n <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		i_arst_n <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		chk(advert, 16'h01e1);
		u_mgmt.frame(32, OP_RD, 5'h01, ADR_EXPAN, 16'h0000, rd);
		chk(rd, exp_val(1'b0, 1'b0));
		stop_test();
	end
endmodule
